/* File: switch_global_control_params.svh */
// Constants for the switch global control register bank
// ----------------------------------------------------------------
// Functional notes
// - Error-drop set in loopback: drop OAM and bad CRC/length frames, loop good.
// - Error-drop clear in loopback: drop OAM only, loop all other frames.
// - Upper position bit ignored while lower position bit is one.
// - LED mode chosen from bits 1 and 7 of the loopback/LED register.
// - LED selects, error-drop and low position bit load from straps in reset.
// - Tag mode bit one enables direct forwarding from port three.
// - Each 802.1p tag 0..7 uses its two-bit remap field as priority.
// - Remap resets to 00,00,01,01,10,10,11,11 for tags zero to seven.
// - Unknown-destination enable sends unknown frames to the port mask.
// - Mask bits 0,1,2 select ports one to three; resets to all ones.
// - PHY address field sets port one address; 00000, 11110, 11111 invalid.
// - Port two PHY address is port one plus one; field resets 00001.
// ----------------------------------------------------------------
`ifndef SWITCH_GLOBAL_CONTROL_PARAMS_SVH
`define SWITCH_GLOBAL_CONTROL_PARAMS_SVH

`define IDX_LOOP_LED 4'hB
`define IDX_REMAP_LOW 4'hC
`define IDX_REMAP_HIGH 4'hD
`define IDX_UNKNOWN_FWD 4'hE
`define IDX_PHY_BASE 4'hF

`define BIT_LED_HIGH 7
`define BIT_ERR_DROP 5
`define BIT_TEST 4
`define BIT_POS_HIGH 3
`define BIT_POS_LOW 2
`define BIT_LED_LOW 1
`define BIT_TAG_MODE 0
`define BIT_UNK_EN 7

`define RST_REMAP_LOW 8'h50
`define RST_REMAP_HIGH 8'hFA
`define RST_UNKNOWN_FWD 8'h07
`define RST_PHY_ADDR 5'h01
`define RST_POS_HIGH 1'b1
`define PHY_ADDR_ZERO 5'h00
`define PHY_ADDR_RES_A 5'h1E
`define PHY_ADDR_RES_B 5'h1F
`define PHY_ADDR_ONE 5'h01
`define READ_ZERO 8'h00

`endif

/* File: switch_global_control_pkg.sv */
// Types for the switch global control register bank
package switch_global_control_pkg;
  typedef enum logic [1:0] {
    LOOP_PORT2_TP = 2'b00,
    LOOP_PORT2_MAC = 2'b01,
    LOOP_PORT1_OPT = 2'b10
  } loop_point_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_DONE = 2'b01
  } bus_state_t;
endpackage

/* File: switch_global_control_regs.sv */
// Global control registers 11 to 15 of the three-port switch
`timescale 1ns/1ns
`include "switch_global_control_params.svh"
module switch_global_control_regs
  import switch_global_control_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [7:0] avs_writedata_i,
  output logic [7:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic indicator_select_low_i,
  input wire logic indicator_select_high_i,
  input wire logic error_drop_strap_i,
  input wire logic loop_position_strap_i,
  input wire logic frame_is_oam_i,
  input wire logic frame_has_error_i,
  input wire logic [2:0] rx_tag_priority_i,
  output logic loop_drop_frame_o,
  output logic [1:0] loop_point_o,
  output logic [1:0] indicator_mode_o,
  output logic direct_forward_tag_mode_o,
  output logic [1:0] internal_priority_o,
  output logic unknown_fwd_en_o,
  output logic [2:0] unknown_fwd_mask_o,
  output logic [4:0] port1_phy_addr_o,
  output logic [4:0] port2_phy_addr_o,
  output logic phy_addr_valid_o
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] loop_led_q;
  logic [7:0] loop_led_d;
  logic [7:0] remap_low_q;
  logic [7:0] remap_high_q;
  logic [7:0] unknown_fwd_q;
  logic [4:0] phy_addr_q;
  bus_state_t bus_state_q;
  bus_state_t bus_state_d;

  function automatic logic [1:0] remap_pick(input logic [15:0] table_v,
                                            input logic [2:0] tag);
    remap_pick = table_v[{tag, 1'b0} +: 2];
  endfunction

  function automatic logic wr_hit(input logic [3:0] addr, input logic [3:0] idx,
                                  input logic wr, input logic st);
    // Caller passes the idle flag, not the two-bit state
    wr_hit = wr && st && addr == idx;
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // One wait cycle: the request is answered on its second edge
  wire logic bus_req = avs_read_i | avs_write_i;
  wire logic st_idle = (bus_state_q == BUS_IDLE);
  wire logic wr_loop = wr_hit(avs_address_i, `IDX_LOOP_LED, avs_write_i, st_idle);
  wire logic wr_rlow = wr_hit(avs_address_i, `IDX_REMAP_LOW, avs_write_i, st_idle);
  wire logic wr_rhigh = wr_hit(avs_address_i, `IDX_REMAP_HIGH, avs_write_i, st_idle);
  wire logic wr_unk = wr_hit(avs_address_i, `IDX_UNKNOWN_FWD, avs_write_i, st_idle);
  wire logic wr_phy = wr_hit(avs_address_i, `IDX_PHY_BASE, avs_write_i, st_idle);
  logic [7:0] rd_mux;
  always_comb begin
    case (avs_address_i)
      `IDX_LOOP_LED: rd_mux = loop_led_q;
      `IDX_REMAP_LOW: rd_mux = remap_low_q;
      `IDX_REMAP_HIGH: rd_mux = remap_high_q;
      `IDX_UNKNOWN_FWD: rd_mux = unknown_fwd_q;
      `IDX_PHY_BASE: rd_mux = {phy_addr_q, 3'h0};
      default: rd_mux = `READ_ZERO;
    endcase
  end
  always_comb begin
    case (bus_state_q)
      BUS_IDLE: bus_state_d = bus_req ? BUS_DONE : BUS_IDLE;
      BUS_DONE: bus_state_d = BUS_IDLE;
      default: bus_state_d = BUS_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Straps sampled every cycle of reset; last value before release sticks
  always_comb begin
    loop_led_d = `READ_ZERO;
    loop_led_d[`BIT_LED_HIGH] = indicator_select_high_i;
    loop_led_d[`BIT_ERR_DROP] = error_drop_strap_i;
    loop_led_d[`BIT_POS_HIGH] = `RST_POS_HIGH;
    loop_led_d[`BIT_POS_LOW] = loop_position_strap_i;
    loop_led_d[`BIT_LED_LOW] = indicator_select_low_i;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bus_state_q <= BUS_IDLE;
      loop_led_q <= loop_led_d;
      remap_low_q <= `RST_REMAP_LOW;
      remap_high_q <= `RST_REMAP_HIGH;
      unknown_fwd_q <= `RST_UNKNOWN_FWD;
      phy_addr_q <= `RST_PHY_ADDR;
    end else if (clk_en_i) begin
      bus_state_q <= bus_state_d;
      if (wr_loop) loop_led_q <= avs_writedata_i;
      if (wr_rlow) remap_low_q <= avs_writedata_i;
      if (wr_rhigh) remap_high_q <= avs_writedata_i;
      if (wr_unk) unknown_fwd_q <= avs_writedata_i;
      if (wr_phy) phy_addr_q <= avs_writedata_i[7:3];
    end
  end

  // ----------------------------------------------------------------
  // Derived controls
  // ----------------------------------------------------------------
  wire logic pos_low = loop_led_q[`BIT_POS_LOW];
  // Upper bit is a don't-care once the low bit selects the optical side
  wire loop_point_t point_sel = pos_low ? LOOP_PORT1_OPT :
    (loop_led_q[`BIT_POS_HIGH] ? LOOP_PORT2_MAC : LOOP_PORT2_TP);
  wire logic drop_now = frame_is_oam_i |
    (loop_led_q[`BIT_ERR_DROP] & frame_has_error_i);
  wire logic [1:0] prio_now =
    remap_pick({remap_high_q, remap_low_q}, rx_tag_priority_i);
  wire logic [4:0] addr1 = phy_addr_q;
  wire logic addr_ok = addr1 != `PHY_ADDR_ZERO && addr1 != `PHY_ADDR_RES_A &&
    addr1 != `PHY_ADDR_RES_B;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= `READ_ZERO;
      avs_waitrequest_o <= 1'b1;
      loop_drop_frame_o <= 1'b0;
      loop_point_o <= LOOP_PORT2_TP;
      indicator_mode_o <= 2'h0;
      direct_forward_tag_mode_o <= 1'b0;
      internal_priority_o <= 2'h0;
      unknown_fwd_en_o <= 1'b0;
      unknown_fwd_mask_o <= 3'h7;
      port1_phy_addr_o <= `RST_PHY_ADDR;
      port2_phy_addr_o <= `RST_PHY_ADDR + `PHY_ADDR_ONE;
      phy_addr_valid_o <= 1'b1;
    end else if (clk_en_i) begin
      avs_readdata_o <= rd_mux;
      avs_waitrequest_o <= !(st_idle && bus_req);
      loop_drop_frame_o <= drop_now;
      loop_point_o <= point_sel;
      indicator_mode_o <= {loop_led_q[`BIT_LED_HIGH], loop_led_q[`BIT_LED_LOW]};
      direct_forward_tag_mode_o <= loop_led_q[`BIT_TAG_MODE];
      internal_priority_o <= prio_now;
      unknown_fwd_en_o <= unknown_fwd_q[`BIT_UNK_EN];
      unknown_fwd_mask_o <= unknown_fwd_q[2:0];
      port1_phy_addr_o <= addr1;
      port2_phy_addr_o <= addr1 + `PHY_ADDR_ONE;
      phy_addr_valid_o <= addr_ok;
    end
  end

endmodule

/* File: switch_global_control_checker.sv */
// Assertion checker for the switch global control register bank
`timescale 1ns/1ns
module switch_global_control_checker (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [7:0] avs_writedata_i,
  input wire logic [7:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic frame_is_oam_i,
  input wire logic frame_has_error_i,
  input wire logic loop_drop_frame_o,
  input wire logic [1:0] loop_point_o,
  input wire logic unknown_fwd_en_o,
  input wire logic [2:0] unknown_fwd_mask_o,
  input wire logic [4:0] port1_phy_addr_o,
  input wire logic [4:0] port2_phy_addr_o,
  input wire logic phy_addr_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // --------------------------------
  // Properties
  // --------------------------------
  wire req = (avs_read_i || avs_write_i) && clk_en_i && avs_waitrequest_o;
  ack_one_cycle_a: assert property (req |=> !avs_waitrequest_o)
    else $error("request not answered in one cycle");
  ack_release_a: assert property (!avs_waitrequest_o && clk_en_i |=> avs_waitrequest_o)
    else $error("answer held too long");
  unmapped_zero_a: assert property (req && avs_read_i && avs_address_i < 4'hB
    |=> avs_readdata_o == 8'h00) else $error("unmapped read not zero");
  drop_class_a: assert property (clk_en_i && !frame_has_error_i
    |=> loop_drop_frame_o == $past(frame_is_oam_i)) else $error("clean frame drop wrong");
  oam_drop_a: assert property (clk_en_i && frame_is_oam_i |=> loop_drop_frame_o)
    else $error("control frame looped back");
  port2_next_a: assert property (port2_phy_addr_o == port1_phy_addr_o + 5'h01)
    else $error("second address not one above");
  phy_valid_a: assert property (phy_addr_valid_o ==
    !(port1_phy_addr_o inside {5'h00, 5'h1E, 5'h1F})) else $error("address validity wrong");
  loop_code_a: assert property (loop_point_o != 2'b11)
    else $error("loop position code out of range");
  fwd_mask_a: assert property (req && avs_write_i && avs_address_i == 4'hE ##1 clk_en_i
    |=> {unknown_fwd_en_o, 4'h0, unknown_fwd_mask_o} == ($past(avs_writedata_i, 2) & 8'h87))
    else $error("forward mask not applied");
  cover property (req && avs_write_i);
  cover property (req && avs_read_i);
  cover property (frame_has_error_i && !frame_is_oam_i ##1 loop_drop_frame_o);
endmodule

/* File: test_switch_global_control_regs.sv */
// Self-checking testbench for the switch global control register bank
`timescale 1ns/1ns
module test_switch_global_control_regs;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, clk_en_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic [7:0] avs_writedata_i = 8'h00, avs_readdata_o, q;
  logic indicator_select_low_i = 1'b0, indicator_select_high_i = 1'b0;
  logic error_drop_strap_i = 1'b0, loop_position_strap_i = 1'b0, frame_is_oam_i = 1'b0;
  logic frame_has_error_i = 1'b0, avs_waitrequest_o, loop_drop_frame_o, phy_addr_valid_o;
  logic [2:0] rx_tag_priority_i = 3'h0, unknown_fwd_mask_o;
  logic [1:0] loop_point_o, indicator_mode_o, internal_priority_o;
  logic direct_forward_tag_mode_o, unknown_fwd_en_o;
  logic [4:0] port1_phy_addr_o, port2_phy_addr_o;
  int fail_count = 0, tests_run = 0;
  // Rows of address, write data, expected read back; test bit 4 of 0xB kept zero
  logic [19:0] rows [6] = '{20'hC1B1B, 20'hDE4E4, 20'hE8585, 20'hFA7A0, 20'h35A00, 20'hB0D0D};
  logic [7:0] defaults [5] = '{8'hAA, 8'h50, 8'hFA, 8'h07, 8'h08};
  switch_global_control_regs switch_global_control_regs_inst (.*);
  always #4 clk_i = ~clk_i;
  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clk_i);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 50) fail_count++;
  endtask
  task automatic settle();
    repeat (2) @(posedge clk_i);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    foreach (rows[i]) begin
      bus(1'b1, rows[i][19:16], rows[i][15:8]);
      bus(1'b0, rows[i][19:16], 8'h00);
      check("readback", rows[i][7:0], q);
    end
    for (int t = 0; t < 8; t++) begin
      @(posedge clk_i);
      rx_tag_priority_i <= 3'(t);
      settle();
      check("priority", (t < 4 ? 8'h1B : 8'hE4) >> (2 * (t % 4)) & 8'h03,
        {6'h00, internal_priority_o});
    end
    check("forward", 8'h85, {unknown_fwd_en_o, 4'h0, unknown_fwd_mask_o});
    check("phy1", 8'h14, {3'h0, port1_phy_addr_o});
    check("phy2", 8'h15, {3'h0, port2_phy_addr_o});
    check("modes", 8'h88, {loop_point_o, indicator_mode_o, direct_forward_tag_mode_o, 3'h0});
    frame_has_error_i <= 1'b1;
    settle();
    check("keep", 8'h00, {7'h00, loop_drop_frame_o});
    bus(1'b1, 4'hB, 8'h28);
    settle();
    check("drop", 8'h01, {7'h00, loop_drop_frame_o});
    check("point", 8'h01, {6'h00, loop_point_o});
    frame_has_error_i <= 1'b0;
    frame_is_oam_i <= 1'b1;
    bus(1'b1, 4'hB, 8'h00);
    settle();
    check("oam", 8'h01, {7'h00, loop_drop_frame_o});
    check("point", 8'h00, {6'h00, loop_point_o});
    frame_is_oam_i <= 1'b0;
    bus(1'b1, 4'hF, 8'hF0);
    settle();
    check("valid", 8'h00, {7'h00, phy_addr_valid_o});
    // Enable low must freeze the drop output
    clk_en_i <= 1'b0;
    frame_is_oam_i <= 1'b1;
    settle();
    check("frozen", 8'h00, {7'h00, loop_drop_frame_o});
    clk_en_i <= 1'b1;
    frame_is_oam_i <= 1'b0;
    // Second reset with LED and error-drop straps raised, position strap left low
    indicator_select_low_i <= 1'b1;
    indicator_select_high_i <= 1'b1;
    error_drop_strap_i <= 1'b1;
    sys_rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    foreach (defaults[i]) begin
      bus(1'b0, 4'hB + 4'(i), 8'h00);
      check("default", defaults[i], q);
    end
    check("strap", 8'hD7, {indicator_mode_o, loop_point_o, unknown_fwd_en_o, unknown_fwd_mask_o});
    tally_and_finish();
  end
  // Run needs about 110 cycles; this allows over twenty times that
  initial begin
    #20000;
    fail_count++;
    tally_and_finish();
  end
endmodule
bind switch_global_control_regs switch_global_control_checker checker_inst (.*);
